// file: design/dac_start_consts.svh
// constants for the converter start-up controller
// included by the controller module only
`ifndef DAC_START_CONSTS_SVH
`define DAC_START_CONSTS_SVH
`define MCLK_PERIOD_NS 4
`define SPI_HALF_NS 16
`define SPI_FRAME_BITS 5'h18
`define SPI_INSTR_BITS 5'h10
// device register addresses and values
`define DEV_CHIP_CATEGORY 15'h0003
`define DEV_PRODUCT_ID_LO 15'h0004
`define DEV_PRODUCT_ID_HI 15'h0005
`define DEV_SILICON_REV 15'h0006
`define DEV_INTERRUPT_EN 15'h0020
`define DEV_BIAS_CTRL 15'h0040
`define DEV_REFERENCE_CTRL 15'h0058
`define DEV_CLK_RECEIVER 15'h0080
`define DEV_CLK_LOOP_PWR 15'h0090
`define DEV_CLK_LOOP_CFG 15'h0091
`define DEV_CLK_LOOP_STAT 15'h0092
`define DEV_ANALOG_PARAM 15'h009E
`define DEV_CAL_ENABLE 15'h00E8
`define DEV_DECODE_MODE 15'h0152
`define DEV_BOOT_LOADER 15'h0604
`define VAL_BOOT_LOAD 8'h01
`define VAL_REFERENCE_ON 8'h03
`define VAL_LOOP_POWER 8'h1E
`define VAL_ZERO 8'h00
`define VAL_IRQ_ALL 8'h0F
`define VAL_ANALOG 8'h85
`define VAL_LOOP_CFG 8'hE9
`define VAL_CAL_ON 8'h20
`define BOOT_PASS_BIT 1
`define LOOP_LOCK_BIT 0
// step sequence indices
`define STEP_FIRST_ID 5'h01
`define STEP_BOOT_CHK 5'h05
`define STEP_IRQ 5'h0A
// software register map
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IDENT 8'h08
`define CTRL_START 0
`define CTRL_READ_IDS 1
`define CTRL_IRQ_EN 2
`define CTRL_MODE_LO 4
`define CTRL_MODE_HI 5
`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_BOOT_FAIL 2
`define STAT_LOCKED 3
`define STAT_STEP_LO 8
`define STAT_STEP_HI 12
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// file: design/dac_start_pkg.sv
// types for the converter start-up controller
// uses none of the macros from the constants header
package dac_start_pkg;
  typedef enum logic [2:0] {
    OP_WR = 3'b000, OP_RD_ID = 3'b001, OP_RD_BOOT = 3'b010,
    OP_POLL = 3'b011, OP_END = 3'b100
  } op_kind_t;
  typedef struct packed {
    op_kind_t kind;
    logic [14:0] addr;
    logic [7:0] data;
  } step_t;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00, SEQ_FETCH = 2'b01, SEQ_XFER = 2'b10,
    SEQ_CHECK = 2'b11
  } seq_state_t;
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdio_tx;
    logic sdio_drive;
  } spi_pins_t;
  typedef struct packed {
    seq_state_t seq;
    logic [4:0] step;
    logic [3:0] div;
    logic [4:0] bit_cnt;
    logic [23:0] shift;
    logic [7:0] rx;
    logic rd;
    spi_pins_t pins;
    logic [31:0] ids;
    logic busy;
    logic done;
    logic boot_fail;
    logic locked;
    logic read_ids;
    logic irq_en;
    logic [1:0] mode;
    logic awready;
    logic wready;
    logic aw_have;
    logic w_have;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_t;
endpackage : dac_start_pkg

// file: design/dac_startup_sequence.sv
// host controller running the converter power-up register sequence
// assumes a 3-wire serial port on the device and AXI4-Lite software
// Notes on behaviour
// - optionally read chip category, product id bytes, revision
// - read boot loader bit 1; one means calibration load succeeded
// - after boot check write 0x03 to the reference control
// - then write 0x1E to power the clock delay-locked loop
// - then write zero to enable the clock receiver
// - then write zero to enable the bias circuits
// - optionally write 0x0F to the interrupt enable register
// - write 0x85 to analog parameters, then 0xE9 to loop config
// - after lock write 0x20 to calibration enable
// - decode mode field bits 1:0: 00 nrz, 01 mixing, 10 rz
// - rerun whole sequence after every power-down or reset; a reset here leaves it idle until software writes start again
// - first write 0x01 to boot loader to load calibration
`timescale 1ns/1ps
`include "dac_start_consts.svh"
module dac_startup_sequence (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output dac_start_pkg::spi_pins_t spi_pins,
  input wire logic sdio_rx
);
  localparam logic [3:0] SPI_HALF_CYC =
    4'(`SPI_HALF_NS / `MCLK_PERIOD_NS);

  dac_start_pkg::state_t s_r;
  dac_start_pkg::state_t s_nxt;

  // the fixed sequence; a read carries no data byte
  function automatic dac_start_pkg::step_t step_of(
    input logic [4:0] idx, input logic [1:0] mode);
    dac_start_pkg::step_t st;
    st = '{dac_start_pkg::OP_END, 15'h0000, `VAL_ZERO};
    unique case (idx)
      5'h00: st = '{dac_start_pkg::OP_WR, `DEV_BOOT_LOADER,
                    `VAL_BOOT_LOAD};
      5'h01: st = '{dac_start_pkg::OP_RD_ID, `DEV_CHIP_CATEGORY,
                    `VAL_ZERO};
      5'h02: st = '{dac_start_pkg::OP_RD_ID, `DEV_PRODUCT_ID_LO,
                    `VAL_ZERO};
      5'h03: st = '{dac_start_pkg::OP_RD_ID, `DEV_PRODUCT_ID_HI,
                    `VAL_ZERO};
      5'h04: st = '{dac_start_pkg::OP_RD_ID, `DEV_SILICON_REV,
                    `VAL_ZERO};
      5'h05: st = '{dac_start_pkg::OP_RD_BOOT, `DEV_BOOT_LOADER,
                    `VAL_ZERO};
      5'h06: st = '{dac_start_pkg::OP_WR, `DEV_REFERENCE_CTRL,
                    `VAL_REFERENCE_ON};
      5'h07: st = '{dac_start_pkg::OP_WR, `DEV_CLK_LOOP_PWR,
                    `VAL_LOOP_POWER};
      5'h08: st = '{dac_start_pkg::OP_WR, `DEV_CLK_RECEIVER,
                    `VAL_ZERO};
      5'h09: st = '{dac_start_pkg::OP_WR, `DEV_BIAS_CTRL,
                    `VAL_ZERO};
      5'h0A: st = '{dac_start_pkg::OP_WR, `DEV_INTERRUPT_EN,
                    `VAL_IRQ_ALL};
      5'h0B: st = '{dac_start_pkg::OP_WR, `DEV_ANALOG_PARAM,
                    `VAL_ANALOG};
      5'h0C: st = '{dac_start_pkg::OP_WR, `DEV_CLK_LOOP_CFG,
                    `VAL_LOOP_CFG};
      5'h0D: st = '{dac_start_pkg::OP_POLL, `DEV_CLK_LOOP_STAT,
                    `VAL_ZERO};
      5'h0E: st = '{dac_start_pkg::OP_WR, `DEV_CAL_ENABLE,
                    `VAL_CAL_ON};
      5'h0F: st = '{dac_start_pkg::OP_WR, `DEV_DECODE_MODE,
                    {6'h00, mode}};
      default: st = '{dac_start_pkg::OP_END, 15'h0000, `VAL_ZERO};
    endcase
    return st;
  endfunction : step_of

  // optional steps are skipped rather than sent with neutral values
  function automatic logic [4:0] next_step(
    input logic [4:0] idx, input logic read_ids, input logic irq_en);
    logic [4:0] n;
    n = idx + 5'h01;
    if (!read_ids && n == `STEP_FIRST_ID)
      n = `STEP_BOOT_CHK;
    if (!irq_en && n == `STEP_IRQ)
      n = n + 5'h01;
    return n;
  endfunction : next_step

  function automatic logic mapped(input logic [7:0] a);
    return a == `REG_CTRL || a == `REG_STATUS || a == `REG_IDENT;
  endfunction : mapped

  function automatic logic [1:0] mode_of(input logic [31:0] d);
    return d[`CTRL_MODE_HI:`CTRL_MODE_LO];
  endfunction : mode_of

  function automatic logic [31:0] ctrl_word(
    input dac_start_pkg::state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`CTRL_READ_IDS] = s.read_ids;
    w[`CTRL_IRQ_EN] = s.irq_en;
    w[`CTRL_MODE_HI:`CTRL_MODE_LO] = s.mode;
    return w;
  endfunction : ctrl_word

  // step index stays visible so software sees where a stopped run ended
  function automatic logic [31:0] status_word(
    input dac_start_pkg::state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`STAT_BUSY] = s.busy;
    w[`STAT_DONE] = s.done;
    w[`STAT_BOOT_FAIL] = s.boot_fail;
    w[`STAT_LOCKED] = s.locked;
    w[`STAT_STEP_HI:`STAT_STEP_LO] = s.step;
    return w;
  endfunction : status_word

  always_comb begin
    dac_start_pkg::step_t st;
    logic [7:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic [1:0] id_sel;
    st = step_of(s_r.step, s_r.mode);
    wa = s_r.aw_addr;
    wd = s_r.w_data;
    ws = s_r.w_strb;
    id_sel = 2'(s_r.step - `STEP_FIRST_ID);
    s_nxt = s_r;

    // serial port sequencer
    unique case (s_r.seq)
      dac_start_pkg::SEQ_IDLE: begin
        s_nxt.div = 4'h0;
      end
      dac_start_pkg::SEQ_FETCH: begin
        if (st.kind == dac_start_pkg::OP_END) begin
          s_nxt.busy = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.seq = dac_start_pkg::SEQ_IDLE;
        end else begin
          s_nxt.rd = st.kind != dac_start_pkg::OP_WR;
          s_nxt.shift = {s_nxt.rd, st.addr,
                         s_nxt.rd ? `VAL_ZERO : st.data};
          s_nxt.pins.cs_n = 1'b0;
          s_nxt.pins.sclk = 1'b0;
          s_nxt.pins.sdio_tx = s_nxt.rd;
          s_nxt.pins.sdio_drive = 1'b1;
          s_nxt.bit_cnt = 5'h00;
          s_nxt.div = 4'h0;
          s_nxt.seq = dac_start_pkg::SEQ_XFER;
        end
      end
      dac_start_pkg::SEQ_XFER: begin
        s_nxt.div = s_r.div + 4'h1;
        if (s_r.div == SPI_HALF_CYC - 4'h1) begin
          s_nxt.div = 4'h0;
          if (!s_r.pins.sclk) begin
            // device drives read data on the falling edge
            s_nxt.pins.sclk = 1'b1;
            if (s_r.rd && s_r.bit_cnt >= `SPI_INSTR_BITS)
              s_nxt.rx = {s_r.rx[6:0], sdio_rx};
          end else begin
            s_nxt.pins.sclk = 1'b0;
            if (s_r.bit_cnt == `SPI_FRAME_BITS - 5'h01) begin
              s_nxt.pins.cs_n = 1'b1;
              s_nxt.pins.sdio_drive = 1'b0;
              s_nxt.seq = dac_start_pkg::SEQ_CHECK;
            end else begin
              s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
              s_nxt.shift = {s_r.shift[22:0], 1'b0};
              s_nxt.pins.sdio_tx = s_r.shift[22];
              // release the shared data line for the read byte
              s_nxt.pins.sdio_drive =
                !(s_r.rd && s_nxt.bit_cnt >= `SPI_INSTR_BITS);
            end
          end
        end
      end
      dac_start_pkg::SEQ_CHECK: begin
        // one half period plus the fetch clock of chip select high between frames (5 mclk)
        s_nxt.div = s_r.div + 4'h1;
        if (s_r.div == SPI_HALF_CYC - 4'h1) begin
          s_nxt.div = 4'h0;
          s_nxt.step = next_step(s_r.step, s_r.read_ids, s_r.irq_en);
          s_nxt.seq = dac_start_pkg::SEQ_FETCH;
          unique case (st.kind)
            dac_start_pkg::OP_RD_ID:
              s_nxt.ids[{id_sel, 3'b000} +: 8] = s_r.rx;
            dac_start_pkg::OP_RD_BOOT:
              if (!s_r.rx[`BOOT_PASS_BIT]) begin
                s_nxt.boot_fail = 1'b1;
                s_nxt.busy = 1'b0;
                s_nxt.seq = dac_start_pkg::SEQ_IDLE;
              end
            dac_start_pkg::OP_POLL:
              if (s_r.rx[`LOOP_LOCK_BIT])
                s_nxt.locked = 1'b1;
              else
                s_nxt.step = s_r.step;
            default: s_nxt.rd = s_r.rd;
          endcase
        end
      end
    endcase

    // AXI4-Lite write channel; address and data in either order
    if (awvalid && s_r.awready) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.aw_addr = awaddr;
      wa = awaddr;
    end
    if (wvalid && s_r.wready) begin
      s_nxt.w_have = 1'b1;
      s_nxt.w_data = wdata;
      s_nxt.w_strb = wstrb;
      wd = wdata;
      ws = wstrb;
    end
    if (s_r.bvalid && bready)
      s_nxt.bvalid = 1'b0;
    if (s_nxt.aw_have && s_nxt.w_have && !s_r.bvalid) begin
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = mapped(wa) ? `RESP_OKAY : `RESP_SLVERR;
      if (wa == `REG_CTRL && ws[0]) begin
        s_nxt.read_ids = wd[`CTRL_READ_IDS];
        s_nxt.irq_en = wd[`CTRL_IRQ_EN];
        s_nxt.mode = mode_of(wd);
        // a start while busy is ignored; each start reruns from step 0
        if (wd[`CTRL_START] && !s_r.busy) begin
          s_nxt.mode = mode_of(wd);
          s_nxt.step = 5'h00;
          s_nxt.seq = dac_start_pkg::SEQ_FETCH;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
          s_nxt.boot_fail = 1'b0;
          s_nxt.locked = 1'b0;
        end
        if (s_r.busy)
          s_nxt.mode = s_r.mode;
      end
    end
    s_nxt.awready = !s_nxt.aw_have && !s_nxt.bvalid;
    s_nxt.wready = !s_nxt.w_have && !s_nxt.bvalid;

    // AXI4-Lite read channel
    if (s_r.rvalid && rready) begin
      s_nxt.rvalid = 1'b0;
      s_nxt.arready = 1'b1;
    end
    if (arvalid && s_r.arready) begin
      s_nxt.arready = 1'b0;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = mapped(araddr) ? `RESP_OKAY : `RESP_SLVERR;
      s_nxt.rdata = 32'h0000_0000;
      if (araddr == `REG_CTRL)
        s_nxt.rdata = ctrl_word(s_r);
      else if (araddr == `REG_STATUS)
        s_nxt.rdata = status_word(s_r);
      else if (araddr == `REG_IDENT)
        s_nxt.rdata = s_r.ids;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '0;
      s_r.pins.cs_n <= 1'b1;
      s_r.awready <= 1'b1;
      s_r.wready <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign awready = s_r.awready;
  assign wready = s_r.wready;
  assign bvalid = s_r.bvalid;
  assign bresp = s_r.bresp;
  assign arready = s_r.arready;
  assign rvalid = s_r.rvalid;
  assign rresp = s_r.rresp;
  assign rdata = s_r.rdata;
  assign spi_pins = s_r.pins;
endmodule : dac_startup_sequence

// file: verif/dac_dev_model.sv
// behavioural converter behind its 3-wire serial port
// 24-bit frames, bits taken on rising sclk, read data moved on falling
`timescale 1ns/1ps
module dac_dev_model #(
  parameter logic [31:0] IDS = 32'h0,
  parameter int LOCK_POLLS = 2
) (
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdio,
  input wire logic boot_ok,
  output logic sdo
);
  logic [23:0] sh, log[$];
  logic [7:0] rdv;
  logic [4:0] cnt;
  logic [1:0] mode_r;
  logic rd_f, loaded = 1'b0;
  int polls = 0;
  initial sdo = 1'b0;
  always @(negedge cs_n) begin
    cnt = 5'h00;
    rd_f = 1'b0;
  end
  always @(posedge sclk) begin
    if (!cs_n) begin
      sh = {sh[22:0], sdio};
      cnt = cnt + 5'h01;
      if (cnt == 5'h10 && sh[15]) begin
        rd_f = 1'b1;
        case (sh[14:0])
          15'h0003: rdv = IDS[7:0];
          15'h0004: rdv = IDS[15:8];
          15'h0005: rdv = IDS[23:16];
          15'h0006: rdv = IDS[31:24];
          15'h0604: rdv = {6'h00, boot_ok & loaded, 1'b0};
          15'h0092: rdv = {7'h00, polls >= LOCK_POLLS};
          default: rdv = 8'h00;
        endcase
        if (sh[14:0] == 15'h0092) polls++;
      end
      if (cnt == 5'h18) begin
        log.push_back(sh);
        if (sh[23:0] == 24'h060401) loaded = 1'b1;
        if (sh[23:8] == 16'h009E) polls = 0;
        if (sh[23:8] == 16'h0152) mode_r = sh[1:0];
      end
    end
  end
  // released line toggles so a host sampling too late never sees a match
  always @(negedge sclk) begin
    if (!cs_n && rd_f && cnt < 5'h18) begin
      sdo = rdv[7];
      rdv = {rdv[6:0], 1'b0};
    end else sdo = ~sdo;
  end
endmodule : dac_dev_model

// file: verif/dac_startup_sequence_sva.sv
// checker on the controller's bus and serial pins
// bound to the controller, sees only its ports
`timescale 1ns/1ps
module dac_startup_sequence_sva (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire dac_start_pkg::spi_pins_t spi_pins
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd; arvalid && arready; endsequence
  property p_wr_resp; s_wr |=> bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_rd_resp; s_rd |=> rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_wr_err;
    s_wr ##0 !(awaddr inside {8'h00, 8'h04, 8'h08}) |=> bresp == 2'h2;
  endproperty
  a_wr_err: assert property (p_wr_err) else $error("unmapped write ok");
  property p_rd_err;
    s_rd ##0 !(araddr inside {8'h00, 8'h04, 8'h08})
      |=> rresp == 2'h2 && rdata == 32'h0;
  endproperty
  a_rd_err: assert property (p_rd_err) else $error("unmapped read ok");
  property p_sclk_half;
    $rose(spi_pins.sclk) |-> spi_pins.sclk [*4] ##1 !spi_pins.sclk;
  endproperty
  a_sclk_half: assert property (p_sclk_half) else $error("sclk high time");
  property p_tx_stable;
    spi_pins.sclk && $past(spi_pins.sclk) |-> $stable(spi_pins.sdio_tx);
  endproperty
  a_tx_stable: assert property (p_tx_stable) else $error("data moved high");
  // a lock report can only follow a passed boot check
  property p_lock_after_boot;
    s_rd ##0 araddr == 8'h04 |=> !(rdata[3] && rdata[2]);
  endproperty
  a_lock_after_boot: assert property (p_lock_after_boot)
    else $error("lock reported after boot failure");
endmodule : dac_startup_sequence_sva
bind dac_startup_sequence dac_startup_sequence_sva sva_inst (.mclk, .rst_b,
  .awaddr, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
  .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .spi_pins);

// file: verif/dac_startup_sequence_tb.sv
// bench for the converter start-up controller
// device model on the serial pins, checker bound to the controller
`timescale 1ns/1ps
module dac_startup_sequence_tb;
  localparam logic [31:0] IDS = 32'h3C2B1A09; // arbitrary identity values
  localparam int LOCK_POLLS = 2;
  logic mclk = 1'b0, rst_b = 1'b0, boot_ok = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, sdo, sdio_rx;
  logic [1:0] bresp, rresp, rsp;
  dac_start_pkg::spi_pins_t spi_pins;
  logic [23:0] expq[$], seen[$];
  int fails = 0, compares = 0;
  always #2 mclk = ~mclk;
  assign sdio_rx = spi_pins.sdio_drive ? spi_pins.sdio_tx : sdo;
  dac_startup_sequence dac_startup_sequence_inst (.mclk, .rst_b, .awaddr,
    .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .spi_pins, .sdio_rx);
  dac_dev_model #(.IDS(IDS), .LOCK_POLLS(LOCK_POLLS)) dac_dev_model_inst (
    .cs_n(spi_pins.cs_n), .sclk(spi_pins.sclk), .sdio(sdio_rx), .boot_ok,
    .sdo);
  task automatic stop_test;
    if (fails == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input logic hit);
    if (hit) begin
      fails++;
      stop_test();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    rsp = bresp;
    bready <= 1'b0;
    tmo(n == 200);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rd_v = rdata;
    rsp = rresp;
    rready <= 1'b0;
    tmo(n == 200);
  endtask : rd
  task automatic ex(input logic [23:0] v);
    expq.push_back(v);
  endtask : ex
  task automatic reg_check;
    rd(8'h00);
    chk(rd_v, 32'h0);
    rd(8'h0C);
    chk({rsp, rd_v}, {2'h2, 32'h0});
    wr(8'h10, 32'h1, 4'hF);
    chk(rsp, 2'h2);
    // low byte lane off: the control write must leave no trace
    wr(8'h00, 32'h36, 4'hE);
    rd(8'h00);
    chk({rsp, rd_v}, 34'h0);
  endtask : reg_check
  task automatic run_seq(input logic ids, input logic irq,
                         input logic [1:0] mode);
    int n;
    dac_dev_model_inst.log.delete();
    expq.delete();
    ex({1'b0, 15'h0604, 8'h01});
    if (ids) for (n = 0; n < 4; n++) ex({1'b1, 15'(n + 3), IDS[8*n+:8]});
    ex({1'b1, 15'h0604, 6'h00, boot_ok, 1'b0});
    if (boot_ok) begin
      ex({1'b0, 15'h0058, 8'h03});
      ex({1'b0, 15'h0090, 8'h1E});
      ex({1'b0, 15'h0080, 8'h00});
      ex({1'b0, 15'h0040, 8'h00});
      if (irq) ex({1'b0, 15'h0020, 8'h0F});
      ex({1'b0, 15'h009E, 8'h85});
      ex({1'b0, 15'h0091, 8'hE9});
      for (n = 0; n <= LOCK_POLLS; n++)
        ex({1'b1, 15'h0092, 7'h00, n == LOCK_POLLS});
      ex({1'b0, 15'h00E8, 8'h20});
      ex({1'b0, 15'h0152, 6'h00, mode});
    end
    wr(8'h00, {26'h0, mode, 1'b0, irq, ids, 1'b1}, 4'hF);
    for (n = 0; n < 2000; n++) begin
      rd(8'h04);
      if (!rd_v[0] && (rd_v[1] || rd_v[2])) break;
    end
    tmo(n == 2000);
    chk(rd_v[3:0], {boot_ok, !boot_ok, boot_ok, 1'b0});
    rd(8'h00);
    chk(rd_v, {26'h0, mode, 1'b0, irq, ids, 1'b0});
    rd(8'h08);
    if (ids) chk(rd_v, IDS);
    seen = dac_dev_model_inst.log;
    chk(seen.size(), expq.size());
    foreach (expq[i])
      if (i < seen.size())
        chk(seen[i], expq[i]);
    if (boot_ok) chk(dac_dev_model_inst.mode_r, mode);
  endtask : run_seq
  task automatic reset_mid;
    wr(8'h00, 32'h1, 4'hF);
    repeat (300) @(posedge mclk);
    rst_b <= 1'b0;
    repeat (8) @(posedge mclk);
    chk(spi_pins, 4'h8);
    chk({awready, wready, arready, bvalid, rvalid}, 5'h1C);
    rst_b <= 1'b1;
    rd(8'h04);
    chk(rd_v, 32'h0);
  endtask : reset_mid
  initial begin
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    reg_check();
    run_seq(1'b1, 1'b1, 2'h0);
    run_seq(1'b0, 1'b0, 2'h1);
    run_seq(1'b1, 1'b0, 2'h2);
    boot_ok = 1'b0;
    run_seq(1'b1, 1'b1, 2'h1);
    boot_ok = 1'b1;
    reset_mid();
    run_seq(1'b0, 1'b1, 2'h2);
    stop_test();
  end
endmodule : dac_startup_sequence_tb
